// >>> rtl/ioxc_pkg.sv
// constants shared by the expander control block and its serial front end
package ioxc_pkg;
	// register addresses (seven-bit command address field)
	localparam logic [6:0] ADDR_CTRL = 7'h04;
	localparam logic [6:0] ADDR_MASK = 7'h06;
	// control register field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_DETECT_BIT = 7;
	// values after reset: shutdown, detection off, all masked
	localparam logic CTRL_RUN_RESET = 1'h0;
	localparam logic CTRL_DETECT_RESET = 1'h0;
	localparam logic [6:0] MASK_RESET = 7'h00;
	// serial frame layout: D15 read flag, D14-D8 address, D7-D0 data
	localparam int FRAME_READ_BIT = 15;
	localparam logic [4:0] CMD_LAST_CNT = 5'h07;
	localparam logic [4:0] WORD_LAST_CNT = 5'h0F;
	localparam logic [4:0] FRAME_DONE_CNT = 5'h10;
	// number of watched ports (24 to 30)
	localparam int NUM_WATCHED = 7;
	// system clock period in ns (40 MHz)
	localparam int CLOCK_PERIOD_NS = 25;
endpackage : ioxc_pkg

// >>> rtl/ioxc_reg_if.sv
// register access strobes between the serial front end and the register file
`timescale 1ns/100ps
interface ioxc_reg_if;
	logic wr_stb; // one-cycle write request
	logic rd_stb; // one-cycle read request
	logic [6:0] addr; // register address
	logic [7:0] wdata; // write data
	logic [7:0] rdata; // read data, combinational from addr
	modport master (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
	modport slave (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : ioxc_reg_if

// >>> rtl/ioxc_spi.sv
// four-wire serial slave that turns frames into register strobes
`timescale 1ns/100ps
module ioxc_spi (
	// system
	input wire logic clock,
	input wire logic reset_n,
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	// register side
	ioxc_reg_if.master bus
);
	// two-flop synchronisers, stage 1 read only by stage 2
	logic sclk_s1, sclk_s2, sclk_d;
	logic cs_s1, cs_s2;
	logic din_s1, din_s2;
	logic [4:0] bit_cnt; // bits taken in this frame
	logic [14:0] shift_in; // incoming bits so far
	logic [7:0] shift_out; // read data being shifted out
	logic load_pending; // read strobe issued, load data next cycle
	wire sclk_rise = sclk_s2 & ~sclk_d;
	wire sclk_fall = ~sclk_s2 & sclk_d;
	wire frame_active = ~cs_s2;
	wire take_bit = frame_active & sclk_rise & (bit_cnt != ioxc_pkg::FRAME_DONE_CNT);
	wire [7:0] cmd_byte = {shift_in[6:0], din_s2};
	wire [15:0] full_word = {shift_in, din_s2};

	// pin synchronisers; cs idles high
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			{sclk_s1, sclk_s2, sclk_d} <= 3'h0;
			{cs_s1, cs_s2} <= 2'h3;
			{din_s1, din_s2} <= 2'h0;
		end else begin
			{sclk_s1, sclk_s2, sclk_d} <= {sclk, sclk_s1, sclk_s2};
			{cs_s1, cs_s2} <= {cs_n, cs_s1};
			{din_s1, din_s2} <= {din, din_s1};
		end
	end

	// input shifter; extra bits past sixteen are ignored
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= 5'h00;
			shift_in <= 15'h0000;
		end else if (!frame_active) begin
			bit_cnt <= 5'h00;
		end else if (take_bit) begin
			bit_cnt <= bit_cnt + 5'h01;
			shift_in <= full_word[14:0];
		end
	end

	// strobes: read after the command byte, write after the full word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus.rd_stb <= 1'b0;
			bus.wr_stb <= 1'b0;
			bus.addr <= 7'h00;
			bus.wdata <= 8'h00;
		end else begin
			bus.rd_stb <= take_bit & (bit_cnt == ioxc_pkg::CMD_LAST_CNT) & cmd_byte[7];
			bus.wr_stb <= take_bit & (bit_cnt == ioxc_pkg::WORD_LAST_CNT) & ~full_word[ioxc_pkg::FRAME_READ_BIT];
			if (take_bit && bit_cnt == ioxc_pkg::CMD_LAST_CNT) begin
				bus.addr <= cmd_byte[6:0];
			end
			if (take_bit && bit_cnt == ioxc_pkg::WORD_LAST_CNT) begin
				bus.wdata <= full_word[7:0];
			end
		end
	end

	// output shifter; data leaves msb first at each falling sclk
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			load_pending <= 1'b0;
			shift_out <= 8'h00;
			dout <= 1'b0;
		end else begin
			load_pending <= bus.rd_stb;
			if (!frame_active) begin
				shift_out <= 8'h00;
				dout <= 1'b0;
			end else if (load_pending) begin
				shift_out <= bus.rdata;
			end else if (sclk_fall) begin
				dout <= shift_out[7];
				shift_out <= {shift_out[6:0], 1'b0};
			end
		end
	end
endmodule : ioxc_spi

// >>> rtl/ioxc_top.sv
// control and transition-detect mask registers of the i/o expander
`timescale 1ns/100ps
module ioxc_top (
	// system
	input wire logic clock,
	input wire logic reset_n,
	// serial interface
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	// watched port levels, ports 24 to 30
	input wire logic [6:0] port_level,
	// device state
	output logic run_mode,
	output logic detect_en,
	output logic [6:0] detect_mask,
	output logic change_irq
);
	ioxc_reg_if bus ();
	logic [6:0] port_s1, port_s2, port_prev; // synchronisers and last level
	// the serial slave owns the pins and issues register strobes
	ioxc_spi u_spi (
		.clock(clock),
		.reset_n(reset_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.din(din),
		.dout(dout),
		.bus(bus)
	);

	// address decode
	wire hit_ctrl = bus.addr == ioxc_pkg::ADDR_CTRL;
	wire hit_mask = bus.addr == ioxc_pkg::ADDR_MASK;
	wire wr_ctrl = bus.wr_stb & hit_ctrl;
	wire wr_mask = bus.wr_stb & hit_mask;
	// read image: bits 6..1 of control and bit 7 of mask read zero
	wire [7:0] ctrl_image = {detect_en, 6'h00, run_mode};
	wire [7:0] mask_image = {1'b0, detect_mask};
	assign bus.rdata = hit_ctrl ? ctrl_image : (hit_mask ? mask_image : 8'h00);
	// level changes of unmasked ports while detection is enabled
	wire [6:0] port_changed = port_s2 ^ port_prev;
	wire change_hit = detect_en & |(port_changed & detect_mask);
	// reading control acknowledges the interrupt
	wire irq_ack = bus.rd_stb & hit_ctrl;

	// control register; shutdown and detect bits are written independently
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			run_mode <= ioxc_pkg::CTRL_RUN_RESET;
			detect_en <= ioxc_pkg::CTRL_DETECT_RESET;
		end else if (wr_ctrl) begin
			run_mode <= bus.wdata[ioxc_pkg::CTRL_RUN_BIT];
			detect_en <= bus.wdata[ioxc_pkg::CTRL_DETECT_BIT];
		end
	end

	// mask register; data bit 7 is simply not stored
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			detect_mask <= ioxc_pkg::MASK_RESET;
		end else if (wr_mask) begin
			detect_mask <= bus.wdata[6:0];
		end
	end

	// port synchronisers; prev tracks always, so enabling gives no false edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			port_s1 <= 7'h00;
			port_s2 <= 7'h00;
			port_prev <= 7'h00;
		end else begin
			port_s1 <= port_level;
			port_s2 <= port_s1;
			port_prev <= port_s2;
		end
	end

	// sticky interrupt; a new change beats the acknowledge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			change_irq <= 1'b0;
		end else if (change_hit) begin
			change_irq <= 1'b1;
		end else if (irq_ack) begin
			change_irq <= 1'b0;
		end
	end

	// helper: mask written since reset
	logic mask_touched;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mask_touched <= 1'b0;
		end else if (wr_mask) begin
			mask_touched <= 1'b1;
		end
	end

	// helper: control bits as last written, kept apart from the registers
	logic shadow_run; // bit 0 of the last control write
	logic shadow_detect; // bit 7 of the last control write
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shadow_run <= ioxc_pkg::CTRL_RUN_RESET;
			shadow_detect <= ioxc_pkg::CTRL_DETECT_RESET;
		end else if (wr_ctrl) begin
			shadow_run <= bus.wdata[ioxc_pkg::CTRL_RUN_BIT];
			shadow_detect <= bus.wdata[ioxc_pkg::CTRL_DETECT_BIT];
		end
	end

	// helper: mask bits as last written; the top data bit has nowhere to go
	logic [ioxc_pkg::NUM_WATCHED-1:0] shadow_mask; // watched ports as last written
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shadow_mask <= ioxc_pkg::MASK_RESET;
		end else if (wr_mask) begin
			shadow_mask <= bus.wdata[6:0];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_ctrl_read_zero;
		hit_ctrl |-> (bus.rdata[6:1] == 6'h00 && bus.rdata[0] == run_mode && bus.rdata[7] == detect_en);
	endproperty
	a_ctrl_read_zero: assert property (p_ctrl_read_zero) else $error("control read image wrong");

	property p_run_write;
		wr_ctrl |=> run_mode == $past(bus.wdata[0]);
	endproperty
	a_run_write: assert property (p_run_write) else $error("shutdown bit not taken");

	property p_run_hold;
		!wr_ctrl |=> $stable(run_mode) && $stable(detect_en);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("control changed without write");

	property p_detect_indep;
		(wr_ctrl && bus.wdata[7] && !bus.wdata[0]) |=> detect_en && !run_mode;
	endproperty
	a_detect_indep: assert property (p_detect_indep) else $error("detect bit tied to shutdown");

	property p_mask_write;
		wr_mask |=> detect_mask == $past(bus.wdata[6:0]) && (!hit_mask || bus.rdata[7] == 1'b0);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write or read wrong");

	property p_mask_reset;
		!mask_touched |-> detect_mask == 7'h00;
	endproperty
	a_mask_reset: assert property (p_mask_reset) else $error("mask not clear after reset");

	property p_irq_set;
		change_hit |=> change_irq;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("change did not raise interrupt");

	property p_irq_cause;
		$rose(change_irq) |-> $past(detect_en) && ($past(port_changed) & $past(detect_mask)) != 7'h00;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without unmasked change");

	// register checks; mapped read images and shutdown state against the write history, unmapped reads against zero, write and hold checks on the register nets
	property p_ctrl_read_image;
		hit_ctrl |-> bus.rdata == {shadow_detect, 6'h00, shadow_run};
	endproperty
	a_ctrl_read_image: assert property (p_ctrl_read_image) else $error("control read wrong");

	property p_mask_read_image;
		hit_mask |-> bus.rdata == {1'b0, shadow_mask};
	endproperty
	a_mask_read_image: assert property (p_mask_read_image) else $error("mask read wrong");

	property p_unmapped_read;
		(!hit_ctrl && !hit_mask) |-> bus.rdata == 8'h00;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped address reads nonzero");

	property p_run_state;
		run_mode == shadow_run;
	endproperty
	a_run_state: assert property (p_run_state) else $error("shutdown state differs from last write");

	property p_detect_write;
		wr_ctrl |=> detect_en == $past(bus.wdata[7]);
	endproperty
	a_detect_write: assert property (p_detect_write) else $error("detect bit not taken");

	property p_run_indep;
		(wr_ctrl && !bus.wdata[7] && bus.wdata[0]) |=> run_mode && !detect_en;
	endproperty
	a_run_indep: assert property (p_run_indep) else $error("shutdown bit tied to detect");

	property p_mask_hold;
		!wr_mask |=> $stable(detect_mask);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

	// interrupt checks; a disabled detector must stay silent
	property p_irq_quiet;
		!detect_en |=> !$rose(change_irq);
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt while detection disabled");

	property p_irq_hold;
		(change_irq && !irq_ack) |=> change_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without acknowledge");

	property p_irq_clear;
		(irq_ack && !change_hit) |=> !change_irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared by control read");

	c_ctrl_write: cover property (wr_ctrl && bus.wdata[7] && bus.wdata[0]);
	c_irq_raise: cover property ($rose(change_irq));
	c_irq_ack: cover property (change_irq && irq_ack ##1 !change_irq);
	c_mask_read: cover property (bus.rd_stb && hit_mask);
	c_mask_write: cover property (wr_mask && bus.wdata[7]);
endmodule : ioxc_top

// >>> dv/ioxc_host.sv
// host model that drives four-wire serial frames into the expander
`timescale 1ns/100ps
module ioxc_host (
	// system
	input wire logic clock,
	// serial pins
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	localparam int HALF = 5; // clocks per sclk half, above the three-clock minimum
	// idle: deselected, serial clock parked low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// one 16-bit word msb first; the low byte of dout is gathered at the end of each high half
	task automatic frame(input logic [15:0] word, output logic [7:0] rdata);
		rdata = 8'h00;
		@(negedge clock) cs_n = 1'b0;
		repeat (HALF) @(negedge clock);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = word[i];
			repeat (HALF) @(negedge clock);
			sclk = 1'b1;
			repeat (HALF) @(negedge clock);
			if (i < 8) rdata[i] = dout; // dout only moves at falls, so stable here
		end
		cs_n = 1'b1;
		sclk = 1'b0; // clock stands still between frames
		din = ~din; // released line shows no stale value
		repeat (HALF) @(negedge clock);
	endtask : frame
endmodule : ioxc_host

// >>> dv/tb.sv
// self-checking bench for the expander control and mask registers
`timescale 1ns/100ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin mismatches++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, act, exp); end end
module tb;
	localparam logic [6:0] CTRL = ioxc_pkg::ADDR_CTRL; // short alias
	localparam logic [6:0] MASK = ioxc_pkg::ADDR_MASK; // short alias
	logic clock; // 40 MHz system clock
	logic reset_n; // active-low reset
	logic sclk, cs_n, din, dout; // serial pins
	logic [6:0] port_level; // ports 24 to 30
	logic run_mode, detect_en, change_irq; // device state
	logic [6:0] detect_mask; // per-port watch
	logic [7:0] rd; // last read byte
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0; // hang guard
	// clock
	initial clock = 1'b0;
	always #(ioxc_pkg::CLOCK_PERIOD_NS / 2.0) clock = ~clock;
	ioxc_top dut (.clock(clock), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.port_level(port_level), .run_mode(run_mode), .detect_en(detect_en), .detect_mask(detect_mask),
		.change_irq(change_irq));
	ioxc_host host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
	// about 18 frames of 170 clocks expected; far above that means a hang
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end
	// counts, verdict, end of run
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	// write frame: read flag low
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.frame({1'b0, a, d}, rd);
	endtask : wr
	// read frame, data returned in the same frame
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		host.frame({1'b1, a, 8'h00}, rd);
		`CHK(rd, exp)
	endtask : rd_chk
	// move the watched pins, give the sync and compare stages time
	task automatic level(input logic [6:0] v);
		port_level = v;
		repeat (6) @(negedge clock);
	endtask : level
	// main sequence
	initial begin
		reset_n = 1'b0;
		port_level = 7'h00;
		repeat (12) @(negedge clock);
		reset_n = 1'b1;
		repeat (3) @(negedge clock);
		`CHK({run_mode, detect_en, detect_mask, change_irq}, 10'h000)
		rd_chk(CTRL, 8'h00);
		rd_chk(MASK, 8'h00);
		$display("test power_up done");
		// each control bit alone; bit 6 and unused bits read zero
		wr(CTRL, 8'hFE);
		`CHK({run_mode, detect_en}, 2'b01)
		rd_chk(CTRL, 8'h80);
		wr(CTRL, 8'h01);
		`CHK({run_mode, detect_en}, 2'b10)
		rd_chk(CTRL, 8'h01);
		$display("test control done");
		// mask: top bit never stored
		wr(MASK, 8'hFF);
		`CHK(detect_mask, 7'h7F)
		rd_chk(MASK, 8'h7F);
		wr(MASK, 8'hA5);
		`CHK(detect_mask, 7'h25)
		// unmapped address leaves both registers alone and reads zero
		wr(7'h05, 8'hFF);
		`CHK({run_mode, detect_en, detect_mask}, {2'b10, 7'h25})
		rd_chk(7'h05, 8'h00);
		$display("test mask done");
		// detection enabled while shut down, only port 24 watched
		wr(MASK, 8'h01);
		wr(CTRL, 8'h80);
		level(7'h02);
		`CHK(change_irq, 1'b0)
		level(7'h03);
		`CHK(change_irq, 1'b1)
		rd_chk(CTRL, 8'h80);
		`CHK(change_irq, 1'b0)
		level(7'h02);
		`CHK(change_irq, 1'b1)
		rd_chk(CTRL, 8'h80);
		// detection off: a watched change stays quiet
		wr(CTRL, 8'h01);
		level(7'h03);
		`CHK(change_irq, 1'b0)
		$display("test detect done");
		// second reset with state set: all returns to power-up values
		wr(MASK, 8'h7F);
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		repeat (3) @(negedge clock);
		`CHK({run_mode, detect_en, detect_mask, change_irq}, 10'h000)
		rd_chk(MASK, 8'h00);
		$display("test reset done");
		summarize();
	end
endmodule : tb
